// [hw/swdrn_pkg.sv]
package swdrn_pkg;
	localparam int SW_W = 4;
	localparam int CFG_W = 8;
	localparam int CNT_W = 24;
	localparam logic [7:0] RESET_CMD = 8'hA5;
	// Time base: one timeout unit is 1 ms
	localparam int CLK_HZ = 20000000;
	localparam int UNIT_MS = 1;
	localparam int UNIT_CYC = CLK_HZ / 1000 * UNIT_MS;
	// Length of the commanded and expiry reset pulse
	localparam int RST_PULSE_US = 1;
	localparam int RST_PULSE_CYC = CLK_HZ / 1000000 * RST_PULSE_US;
	localparam logic [7:0] CFG_RESET = 8'h00;
	typedef enum logic [1:0] {IDLE, RUN, FIRED} swdrn_state_e;
endpackage

// [hw/swdrn_watchdog.sv]
`timescale 1ns/1ps
module swdrn_watchdog #(
	parameter int UNIT_CYCLES = swdrn_pkg::UNIT_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [swdrn_pkg::SW_W-1:0] configSwitch,
	input wire logic watchdogEnableBit,
	input wire logic expiryActionSelect,
	input wire logic watchdogTriggerBit,
	input wire logic [swdrn_pkg::CFG_W-1:0] wdCfgValue,
	input wire logic optionIdWrite,
	input wire logic [7:0] optionIdData,
	output logic watchdogEventFlag,
	output logic [7:0] switchInputValue,
	output logic systemReset,
	output logic nmiOut
);
	swdrn_pkg::swdrn_state_e state_reg;
	swdrn_pkg::swdrn_state_e state_next;
	logic [31:0] unitCnt_reg;
	logic [31:0] unitCnt_next;
	logic [swdrn_pkg::CNT_W-1:0] units_reg;
	logic [swdrn_pkg::CNT_W-1:0] units_next;
	logic flag_reg;
	logic flag_next;
	logic rst_reg;
	logic rst_next;
	logic nmi_reg;
	logic nmi_next;
	logic [7:0] sw_reg;
	logic [7:0] sw_next;
	logic [7:0] pulse_reg;
	logic [7:0] pulse_next;
	logic [swdrn_pkg::CNT_W-1:0] period;
	logic [swdrn_pkg::CNT_W-1:0] lastUnit;
	logic unitDone;
	logic expire;
	logic fireNow;
	logic actNow;
	logic startPulse;
	logic resetCmd;

	// Period = (switch * 256 + register) units, never zero
	always_comb begin
		period = {{(swdrn_pkg::CNT_W - swdrn_pkg::SW_W - swdrn_pkg::CFG_W){1'b0}},
			configSwitch, wdCfgValue};
		if (period == '0) begin
			period = {{(swdrn_pkg::CNT_W-1){1'b0}}, 1'b1};
		end
		lastUnit = period - {{(swdrn_pkg::CNT_W-1){1'b0}}, 1'b1};
	end

	assign unitDone = (unitCnt_reg == 32'(UNIT_CYCLES - 1));

	// Units run from zero, so the last unit is period - 1
	assign expire = (units_reg == lastUnit) && unitDone;

	// A trigger in the expiry cycle still counts as in time
	assign fireNow = (state_reg == swdrn_pkg::RUN) && watchdogEnableBit &&
		!watchdogTriggerBit && expire;

	// The flag is only set while running, never in idle or fired
	assign actNow = watchdogEnableBit && flag_reg;

	assign startPulse = actNow && !expiryActionSelect && (pulse_reg == '0);

	assign resetCmd = optionIdWrite &&
		(optionIdData == swdrn_pkg::RESET_CMD);

	// Timer group
	always_comb begin
		state_next = state_reg;
		unitCnt_next = unitCnt_reg;
		units_next = units_reg;
		case (state_reg)
			swdrn_pkg::IDLE: begin
				unitCnt_next = '0;
				units_next = '0;
				if (watchdogEnableBit && flag_reg) begin
					state_next = swdrn_pkg::FIRED;
				end else if (watchdogEnableBit) begin
					state_next = swdrn_pkg::RUN;
				end
			end
			swdrn_pkg::RUN: begin
				if (!watchdogEnableBit) begin
					state_next = swdrn_pkg::IDLE;
				end else if (watchdogTriggerBit) begin
					unitCnt_next = '0;
					units_next = '0;
				end else if (expire) begin
					state_next = swdrn_pkg::FIRED;
				end else if (unitDone) begin
					unitCnt_next = '0;
					units_next = units_reg + 1'b1;
				end else begin
					unitCnt_next = unitCnt_reg + 32'h1;
				end
			end
			default: begin
				if (!watchdogEnableBit) begin
					state_next = swdrn_pkg::IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= swdrn_pkg::IDLE;
			unitCnt_reg <= '0;
			units_reg <= '0;
		end else begin
			state_reg <= state_next;
			unitCnt_reg <= unitCnt_next;
			units_reg <= units_next;
		end
	end

	// Flag group
	always_comb begin
		flag_next = flag_reg;
		if (fireNow) begin
			flag_next = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			// Hardware reset is the only path that clears the flag
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	// Action group: re-enable with the flag standing acts at once
	always_comb begin
		nmi_next = actNow && expiryActionSelect;
		pulse_next = pulse_reg;
		if (pulse_reg != '0) begin
			pulse_next = pulse_reg - 8'h01;
		end
		if (startPulse) begin
			pulse_next = 8'(swdrn_pkg::RST_PULSE_CYC);
		end
		if (resetCmd) begin
			pulse_next = 8'(swdrn_pkg::RST_PULSE_CYC);
		end
		// Output follows the next count so a new pulse shows at once
		rst_next = (pulse_next != '0);
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rst_reg <= 1'b0;
			nmi_reg <= 1'b0;
			pulse_reg <= 8'h00;
		end else begin
			rst_reg <= rst_next;
			nmi_reg <= nmi_next;
			pulse_reg <= pulse_next;
		end
	end

	// Switch group: low bits mirror the switch, upper bits read zero
	genvar b;
	generate
		for (b = 0; b < 8; b++) begin : g_sw
			if (b < swdrn_pkg::SW_W) begin : g_pin
				assign sw_next[b] = configSwitch[b];
			end else begin : g_zero
				assign sw_next[b] = 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sw_reg <= 8'h00;
		end else begin
			sw_reg <= sw_next;
		end
	end

	// Outputs come straight from their flip-flops

	assign watchdogEventFlag = flag_reg;
	assign switchInputValue = sw_reg;
	assign systemReset = rst_reg;
	assign nmiOut = nmi_reg;
endmodule

// [test/swdrn_host.sv]
`timescale 1ns/1ps
module swdrn_host (
	input wire logic systemReset,
	input wire logic nmiOut,
	output int nmiCount,
	output int rstCount
);
	initial begin
		nmiCount = 0;
		rstCount = 0;
	end
	// Mask bits taken as set, so every NMI lands
	always @(posedge nmiOut) nmiCount <= nmiCount + 1;
	always @(posedge systemReset) rstCount <= rstCount + 1;
endmodule

// [test/swdrn_monitor.sv]
`timescale 1ns/1ps
module swdrn_monitor #(parameter int UNIT_CYCLES = 4) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic watchdogEnableBit,
	input wire logic expiryActionSelect,
	input wire logic watchdogTriggerBit,
	input wire logic optionIdWrite,
	input wire logic watchdogEventFlag,
	input wire logic systemReset,
	input wire logic nmiOut,
	input wire logic [3:0] configSwitch,
	input wire logic [7:0] optionIdData,
	input wire logic [7:0] switchInputValue
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire flg = watchdogEventFlag, en = watchdogEnableBit;
	off_quiet_a: assert property (
		!en |=> !nmiOut) else $error("nmi while off");
	nmi_follow_a: assert property (
		flg && en && expiryActionSelect |=> nmiOut) else $error("no nmi");
	nmi_cause_a: assert property (
		nmiOut |-> $past(flg) && $past(expiryActionSelect))
		else $error("bad nmi");
	rst_repeat_a: assert property (
		flg && en && !expiryActionSelect |-> ##[1:22] systemReset)
		else $error("no reset");
	cmd_reset_a: assert property (
		optionIdWrite && optionIdData == swdrn_pkg::RESET_CMD |=> systemReset)
		else $error("cmd");
	flag_sticky_a: assert property (
		flg |=> flg) else $error("flag lost");
	trig_restart_a: assert property (
		watchdogTriggerBit ##1 !flg |-> !flg[*3]) else $error("early expiry");
	switch_mirror_a: assert property (
		##1 switchInputValue == {4'h0, $past(configSwitch)})
		else $error("switch");
	cover property ($rose(nmiOut));
	cover property ($rose(systemReset));
	cover property (watchdogTriggerBit);
endmodule
bind swdrn_watchdog swdrn_monitor #(.UNIT_CYCLES(UNIT_CYCLES)) mon (.*);

// [test/swdrn_watchdog_tb.sv]
`timescale 1ns/1ps
module swdrn_watchdog_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic en = 1'b0;
	logic sel = 1'b1;
	logic trig = 1'b0;
	logic wr = 1'b0;
	logic flag;
	logic sRst;
	logic nmi;
	logic [3:0] sw = 4'h0;
	logic [7:0] cfg = 8'h02;
	logic [7:0] dat = 8'h00;
	logic [7:0] swOut;
	// Rows: switch setting, then the expected mirrored value
	logic [11:0] rows [3] = '{12'h000, 12'hA0A, 12'hF0F};
	int nmiN;
	int rstN;
	int n_errors = 0;
	int checks = 0;
	always #25 clk = ~clk;
	swdrn_watchdog #(.UNIT_CYCLES(4)) uut (.clk(clk), .sys_rst(rst),
		.configSwitch(sw), .watchdogEnableBit(en), .expiryActionSelect(sel),
		.watchdogTriggerBit(trig), .wdCfgValue(cfg), .optionIdWrite(wr),
		.optionIdData(dat), .watchdogEventFlag(flag), .switchInputValue(swOut),
		.systemReset(sRst), .nmiOut(nmi));
	swdrn_host host (.systemReset(sRst), .nmiOut(nmi), .nmiCount(nmiN),
		.rstCount(rstN));
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input logic ok);
		checks++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("CHECK FAILED %0t bad", $time);
		end
	endtask
	task automatic conclude;
		if (n_errors == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		#20us;
		n_errors++;
		conclude();
	end
	initial begin
		w(5);
		rst <= 1'b0;
		w(2);
		#1 chk(!flag && !nmi && !sRst);
		foreach (rows[i]) begin
			w(1);
			sw <= rows[i][11:8];
			w(2);
			#1 chk(swOut === rows[i][7:0]);
		end
		// Period of two units, triggers kept one cycle inside it
		w(1);
		sw <= 4'h0;
		en <= 1'b1; // action and timeout already set
		repeat (3) begin
			w(6);
			trig <= 1'b1;
			w(1);
			trig <= 1'b0;
		end
		w(2);
		#1 chk(!flag);
		w(11);
		#1 chk(flag && nmi && nmiN == 1);
		w(1);
		en <= 1'b0;
		w(3);
		#1 chk(!nmi);
		w(1);
		en <= 1'b1;
		w(4);
		#1 chk(nmi && nmiN == 2);
		w(1);
		en <= 1'b0;
		sel <= 1'b0;
		w(2);
		en <= 1'b1;
		w(5);
		#1 chk(sRst && rstN == 1);
		w(1);
		en <= 1'b0;
		w(25);
		wr <= 1'b1;
		dat <= 8'h5A;
		w(1);
		dat <= 8'hA5;
		w(1);
		wr <= 1'b0;
		w(2);
		#1 chk(flag && sRst && rstN == 2);
		w(25);
		rst <= 1'b1;
		w(1);
		rst <= 1'b0;
		w(2);
		#1 chk(!flag);
		// One-unit period from the register alone
		w(1);
		cfg <= 8'h01;
		sel <= 1'b1;
		en <= 1'b1;
		w(4);
		#1 chk(!flag);
		w(1);
		#1 chk(flag);
		conclude();
	end
endmodule
